// >>> nspm_consts.svh
// constants for the nonvolatile section protection map
// What this block does
// - flash store works only from boot section or the programmer port
// - boot-issued flash store may target anywhere
// - decode flash word address into three sections
// - table section equals boot size, below boot
// - application and table have separate locks
// - boot section has its own lock
// - locked sections block write or read
// - factory signature readable, never written or erased
// - reset copies selected calibration values out
// - factory row holds device id and serial
// - user row one page, survives chip erase
// - fuse writes only from the programmer
// - lock writes only toward stricter protection
// - locks cleared by chip erase, last
// - unprogrammed cell reads one, programmed zero
// - flash locations are sixteen bits wide
// - software or programmer port may access flash
// - data space io, eeprom, sram at fixed bases
`ifndef NSPM_CONSTS_SVH
`define NSPM_CONSTS_SVH
// ----------------------------------------
// flash map, word addresses
// ----------------------------------------
`define NSPM_FA_W        17
`define NSPM_BOOT_BASE   17'h10000
`define NSPM_BOOT_LAST   17'h10fff
`define NSPM_BOOT_SIZE   17'h01000
`define NSPM_FLASH_DW    16
// ----------------------------------------
// data map, byte addresses
// ----------------------------------------
`define NSPM_DA_W        16
`define NSPM_IO_LAST     16'h0fff
`define NSPM_EE_BASE     16'h1000
`define NSPM_SRAM_BASE   16'h2000
`define NSPM_EE_SIZE     16'h0800
// ----------------------------------------
// lock levels, programmed bit is zero
// ----------------------------------------
`define NSPM_LOCK_W      2
`define NSPM_LOCK_NONE   2'h3
`define NSPM_LOCK_WR     2'h2
`define NSPM_LOCK_RW     2'h0
`define NSPM_FUSE_RST    8'hff
// ----------------------------------------
// signature rows
// ----------------------------------------
`define NSPM_SIG_AW      5
`define NSPM_CAL_ADDR0   5'h08
`define NSPM_CAL_ADDR1   5'h09
`define NSPM_CAL0_VAL    16'h0080
`define NSPM_CAL1_VAL    16'h0040
`define NSPM_USER_AW     8
`define NSPM_ERASE_CYC   4'hf
`endif

// >>> nspm_pkg.sv
// types for the nonvolatile section protection map
package nspm_pkg;
  typedef enum logic [1:0] {SEC_APP, SEC_TABLE, SEC_BOOT, SEC_NONE} nspm_sec_t;
  typedef enum logic [2:0] {DR_IO, DR_EE, DR_GAP, DR_SRAM, DR_NONE} nspm_dreg_t;
  typedef enum {ST_CAL0, ST_CAL1, ST_RUN, ST_ERASE, ST_UNLOCK} nspm_state_t;
  typedef struct packed {
    logic [1:0] app;
    logic [1:0] table_l;
    logic [1:0] boot;
  } nspm_locks_t;
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        store;
    logic        from_port;
    logic [16:0] addr;
    logic [15:0] wdata;
  } nspm_freq_t;
endpackage : nspm_pkg

// >>> nspm_top.sv
// access control and address decoding for nonvolatile memories
`timescale 1ns/1ps
`include "nspm_consts.svh"
module nspm_top
  import nspm_pkg::*;
#(
  parameter logic [16:0] BOOT_BASE = `NSPM_BOOT_BASE,
  parameter logic [16:0] BOOT_SIZE = `NSPM_BOOT_SIZE,
  parameter logic [15:0] EE_SIZE   = `NSPM_EE_SIZE,
  parameter logic [15:0] DEV_ID0   = 16'h00a5, // arbitrary value
  parameter logic [7:0]  DEV_ID2   = 8'h5a,    // arbitrary value
  parameter int          ERASE_CYC = `NSPM_ERASE_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [16:0] fetch_pc_in,
  input  wire nspm_freq_t  flash_req_in,
  input  wire logic        lock_wr_in,
  input  wire logic        lock_from_port_in,
  input  wire nspm_locks_t lock_wdata_in,
  input  wire logic        fuse_wr_in,
  input  wire logic        fuse_from_port_in,
  input  wire logic [7:0]  fuse_wdata_in,
  input  wire logic        chip_erase_in,
  input  wire logic        user_erase_in,
  input  wire logic        sig_rd_in,
  input  wire logic [4:0]  sig_addr_in,
  input  wire logic        user_wr_in,
  input  wire logic [7:0]  user_addr_in,
  input  wire logic [15:0] user_wdata_in,
  input  wire logic [15:0] data_addr_in,
  input  wire logic        data_wr_in,
  output logic             flash_grant_out,
  output logic             flash_denied_out,
  output nspm_sec_t        flash_sec_out,
  output nspm_locks_t      locks_out,
  output logic [7:0]       fuse_out,
  output logic [15:0]      sig_rdata_out,
  output logic [15:0]      user_rdata_out,
  output logic [7:0]       cal_osc_out,
  output logic [7:0]       cal_adc_out,
  output logic             init_done_out,
  output logic             erase_busy_out,
  output nspm_dreg_t       data_region_out,
  output logic             data_wr_en_out,
  output logic             data_rd_zero_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic nspm_sec_t sec_of(input logic [16:0] a);
    logic [16:0] tbl;
    tbl = BOOT_BASE - BOOT_SIZE;
    if (a >= BOOT_BASE + BOOT_SIZE) sec_of = SEC_NONE;
    else if (a >= BOOT_BASE)        sec_of = SEC_BOOT;
    else if (a >= tbl)              sec_of = SEC_TABLE;
    else                            sec_of = SEC_APP;
  endfunction : sec_of

  // higher strictness means more programmed (zero) bits
  function automatic logic stricter(input logic [1:0] n, input logic [1:0] o);
    stricter = ((n & o) == n);
  endfunction : stricter

  function automatic logic [1:0] lock_of(input nspm_locks_t l,
                                         input nspm_sec_t   s);
    case (s)
      SEC_APP:   lock_of = l.app;
      SEC_TABLE: lock_of = l.table_l;
      SEC_BOOT:  lock_of = l.boot;
      default:   lock_of = `NSPM_LOCK_RW;
    endcase
  endfunction : lock_of

  // ----------------------------------------
  // state
  // ----------------------------------------
  nspm_state_t state_q, state_d;
  nspm_locks_t locks_q;
  logic [7:0]  fuse_q;
  logic [15:0] user_row_q [0:255];
  logic [15:0] sig_rdata_q, user_rdata_q;
  logic [7:0]  cal_osc_q, cal_adc_q;
  logic [15:0] erase_cnt_q;
  logic        grant_q, denied_q;
  nspm_sec_t   sec_q;
  nspm_dreg_t  dreg_q;
  logic        dwr_q, dzero_q;
  // status flags registered so outputs come straight from flops
  logic        init_q, busy_q;

  // factory row is a constant table, no write path exists
  function automatic logic [15:0] sig_rom(input logic [4:0] a);
    case (a)
      5'h00:   sig_rom = DEV_ID0;
      5'h01:   sig_rom = {8'h00, DEV_ID2};
      5'h02:   sig_rom = 16'h1234;            // lot number
      5'h03:   sig_rom = 16'h0003;            // wafer number
      5'h04:   sig_rom = 16'h0c07;            // wafer x, y
      5'h08:   sig_rom = `NSPM_CAL0_VAL;      // oscillator trim
      5'h09:   sig_rom = `NSPM_CAL1_VAL;      // adc trim
      5'h0a:   sig_rom = 16'h0011;            // left for software
      default: sig_rom = 16'h0000;
    endcase
  endfunction : sig_rom

  // a call result cannot be part-selected, so name the words first
  wire logic [15:0] cal0_word = sig_rom(`NSPM_CAL_ADDR0);
  wire logic [15:0] cal1_word = sig_rom(`NSPM_CAL_ADDR1);

  // ----------------------------------------
  // flash access decision
  // ----------------------------------------
  wire nspm_sec_t  tgt_sec   = sec_of(flash_req_in.addr);
  wire nspm_sec_t  pc_sec    = sec_of(fetch_pc_in);
  wire logic [1:0] tgt_lock  = lock_of(locks_q, tgt_sec);
  // software store from app or table is ignored, any target ok from boot
  wire logic store_ok  = !flash_req_in.store
                       || flash_req_in.from_port
                       || (pc_sec == SEC_BOOT);
  // lock bit 0 blocks write, bit 1 blocks read as well
  wire logic wr_block  = !tgt_lock[0] || !tgt_lock[1];
  wire logic rd_block  = !tgt_lock[1];
  wire logic running   = (state_q == ST_RUN);
  // both software and the programmer port reach flash
  wire logic flash_ok  = running && (tgt_sec != SEC_NONE) && store_ok
                       && (flash_req_in.wr ? !wr_block : !rd_block);

  // ----------------------------------------
  // lock and fuse writes
  // ----------------------------------------
  wire logic lock_ok = lock_wr_in && running
                     && stricter(lock_wdata_in.app, locks_q.app)
                     && stricter(lock_wdata_in.table_l, locks_q.table_l)
                     && stricter(lock_wdata_in.boot, locks_q.boot);
  wire logic fuse_ok = fuse_wr_in && fuse_from_port_in;

  // ----------------------------------------
  // data space decode
  // ----------------------------------------
  wire nspm_dreg_t dreg =
      (data_addr_in <= `NSPM_IO_LAST)           ? DR_IO   :
      (data_addr_in <  `NSPM_EE_BASE + EE_SIZE) ? DR_EE   :
      (data_addr_in <  `NSPM_SRAM_BASE)         ? DR_GAP  :
                                                  DR_SRAM;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CAL0:   state_d = ST_CAL1;
      ST_CAL1:   state_d = ST_RUN;
      ST_RUN:    if (chip_erase_in) state_d = ST_ERASE;
      ST_ERASE:  if (erase_cnt_q == 16'(ERASE_CYC)) state_d = ST_UNLOCK;
      ST_UNLOCK: state_d = ST_RUN;
      default:   state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q     <= ST_CAL0;
      locks_q     <= '{`NSPM_LOCK_NONE, `NSPM_LOCK_NONE, `NSPM_LOCK_NONE};
      fuse_q      <= `NSPM_FUSE_RST;
      cal_osc_q   <= 8'h00;
      cal_adc_q   <= 8'h00;
      erase_cnt_q <= 16'h0000;
      init_q      <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      state_q <= state_d;
      init_q  <= (state_d != ST_CAL0) && (state_d != ST_CAL1);
      busy_q  <= (state_d == ST_ERASE) || (state_d == ST_UNLOCK);
      // calibration copied out while starting up
      if (state_q == ST_CAL0)
        cal_osc_q <= cal0_word[7:0];
      if (state_q == ST_CAL1)
        cal_adc_q <= cal1_word[7:0];
      erase_cnt_q <= (state_q == ST_ERASE) ? erase_cnt_q + 16'h0001
                                           : 16'h0000;
      // locks released only once the flash is wiped
      if (state_q == ST_UNLOCK)
        locks_q <= '{`NSPM_LOCK_NONE, `NSPM_LOCK_NONE, `NSPM_LOCK_NONE};
      else if (lock_ok)
        locks_q <= lock_wdata_in;
      if (fuse_ok)
        fuse_q <= fuse_wdata_in;
    end
  end

  // user row kept apart from chip erase
  always_ff @(posedge clk_in) begin
    if (user_erase_in) begin
      for (int i = 0; i < 256; i++)
        user_row_q[i] <= 16'hffff;
    end else if (user_wr_in) begin
      user_row_q[user_addr_in] <= user_wdata_in;
    end
  end

  // ----------------------------------------
  // registered answers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      grant_q      <= 1'b0;
      denied_q     <= 1'b0;
      sec_q        <= SEC_NONE;
      sig_rdata_q  <= 16'h0000;
      user_rdata_q <= 16'h0000;
      dreg_q       <= DR_NONE;
      dwr_q        <= 1'b0;
      dzero_q      <= 1'b0;
    end else begin
      grant_q      <= flash_req_in.req && flash_ok;
      denied_q     <= flash_req_in.req && !flash_ok;
      sec_q        <= tgt_sec;
      if (sig_rd_in)
        sig_rdata_q <= sig_rom(sig_addr_in);
      user_rdata_q <= user_row_q[user_addr_in];
      dreg_q       <= dreg;
      dwr_q        <= data_wr_in && (dreg != DR_GAP);
      dzero_q      <= (dreg == DR_GAP);
    end
  end

  assign flash_grant_out  = grant_q;
  assign flash_denied_out = denied_q;
  assign flash_sec_out    = sec_q;
  assign locks_out        = locks_q;
  assign fuse_out         = fuse_q;
  assign sig_rdata_out    = sig_rdata_q;
  assign user_rdata_out   = user_rdata_q;
  assign cal_osc_out      = cal_osc_q;
  assign cal_adc_out      = cal_adc_q;
  assign init_done_out    = init_q;
  assign erase_busy_out   = busy_q;
  assign data_region_out  = dreg_q;
  assign data_wr_en_out   = dwr_q;
  assign data_rd_zero_out = dzero_q;

endmodule : nspm_top

// >>> nspm_prog_model.sv
// programmer model driving fuse writes over the debug port
`timescale 1ns/1ps
module nspm_prog_model (
  input  wire logic  clk_in,
  output logic       fuse_wr_out = 1'b0,
  output logic       fuse_port_out = 1'b0,
  output logic [7:0] fuse_data_out = 8'h00
);
  // ----------------------------------------
  // fuse access
  // ----------------------------------------
  // port low stands for software making the same attempt
  task automatic write_fuse(input logic [7:0] v, input logic port);
    @(posedge clk_in);
    #1;
    fuse_wr_out = 1'b1;
    fuse_port_out = port;
    fuse_data_out = v;
    @(posedge clk_in);
    #1;
    fuse_wr_out = 1'b0;
    fuse_data_out = ~v; // released data never keeps its last value
  endtask : write_fuse
endmodule : nspm_prog_model

// >>> nspm_top_monitor.sv
// assertion checker for the section protection map
`timescale 1ns/1ps
module nspm_top_monitor
  import nspm_pkg::*;
#(
  parameter logic [15:0] EE_SIZE = 16'h0800
) (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [16:0] fetch_pc_in,
  input wire nspm_freq_t  flash_req_in,
  input wire logic        fuse_wr_in,
  input wire logic        fuse_from_port_in,
  input wire logic [15:0] data_addr_in,
  input wire logic        flash_grant_out,
  input wire logic        flash_denied_out,
  input wire nspm_sec_t   flash_sec_out,
  input wire nspm_locks_t locks_out,
  input wire logic [7:0]  fuse_out,
  input wire logic        erase_busy_out,
  input wire logic        data_wr_en_out,
  input wire logic        data_rd_zero_out
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  wire        rq  = flash_req_in.req;
  wire [16:0] fa  = flash_req_in.addr;
  wire        sto = rq && flash_req_in.store && !flash_req_in.from_port;
  wire        bt  = fetch_pc_in[16:12] == 5'h10;
  wire [1:0]  sec = fa < 17'h0f000 ? 2'h0 : fa < 17'h10000 ? 2'h1 :
                    fa < 17'h11000 ? 2'h2 : 2'h3;
  wire        fok = fuse_wr_in && fuse_from_port_in;
  wire        gap = data_addr_in >= 16'h1000 + EE_SIZE &&
                    data_addr_in < 16'h2000;
  chk_store_pc: assert property (sto && !bt |=> !flash_grant_out)
    else $error("store outside boot");
  chk_addr_top: assert property (rq && sec == 2'h3 |=> !flash_grant_out)
    else $error("address past boot");
  chk_sec_map: assert property (rq |=> flash_sec_out == $past(sec))
    else $error("section decode");
  chk_one_answer: assert property (
    rq |=> flash_grant_out ^ flash_denied_out) else $error("answer");
  chk_lock_stricter: assert property (!$stable(locks_out) |->
    (locks_out & $past(locks_out)) == locks_out || locks_out == 6'h3f)
    else $error("lock relaxed");
  chk_fuse_port: assert property (!$stable(fuse_out) |-> $past(fok))
    else $error("fuse source");
  chk_erase_unlock: assert property (
    $fell(erase_busy_out) |-> ##[0:1] locks_out == 6'h3f) else $error("unlock");
  chk_gap_quiet: assert property (
    gap |=> data_rd_zero_out && !data_wr_en_out) else $error("gap");
endmodule : nspm_top_monitor
bind nspm_top nspm_top_monitor #(.EE_SIZE(EE_SIZE)) u_nspm_top_monitor (.*);

// >>> nspm_top_bench.sv
// self-checking bench for the section protection map
`timescale 1ns/1ps
`include "nspm_consts.svh"
module nspm_top_bench;
  import nspm_pkg::*;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clk_in = 1'b0, nrst_in = 1'b0, lock_wr_in = 1'b0, data_wr_in = 1'b0;
  logic lock_from_port_in = 1'b0, chip_erase_in = 1'b0, user_wr_in = 1'b0;
  logic user_erase_in = 1'b0, sig_rd_in = 1'b0, fuse_wr_in, fuse_from_port_in;
  logic flash_grant_out, flash_denied_out, init_done_out, erase_busy_out;
  logic data_wr_en_out, data_rd_zero_out;
  logic [4:0] sig_addr_in = 5'h0;
  logic [7:0] user_addr_in = 8'h03, fuse_wdata_in, fuse_out, cal_osc_out;
  logic [7:0] cal_adc_out;
  logic [15:0] user_wdata_in = 16'h0, data_addr_in = 16'h0, sig_rdata_out;
  logic [15:0] user_rdata_out;
  logic [16:0] fetch_pc_in = 17'h0;
  nspm_freq_t flash_req_in = '0;
  nspm_locks_t lock_wdata_in = 6'h3f, locks_out;
  nspm_sec_t flash_sec_out;
  nspm_dreg_t data_region_out;
  logic [5:0] mlk = 6'h3f;
  int miscompares = 0, num_checks = 0, run = 0, e, w;
  nspm_top #(.DEV_ID0(16'h1234), .ERASE_CYC(2)) u_nspm_top (.*);
  nspm_prog_model u_nspm_prog_model (.clk_in, .fuse_wr_out(fuse_wr_in),
    .fuse_port_out(fuse_from_port_in), .fuse_data_out(fuse_wdata_in));
  always #2.5 clk_in = ~clk_in;
  initial begin
    #20000;
    miscompares++;
    end_sim;
  end
  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic int sec_of(input logic [16:0] a);
    return a < 17'h0f000 ? 0 : a < 17'h10000 ? 1 : a < 17'h11000 ? 2 : 3;
  endfunction : sec_of
  // back to back is legal, so the caller lowers req
  task automatic flash(input logic [16:0] a, input bit wr, st, port,
                       input logic [16:0] pc);
    int s;
    s = sec_of(a);
    flash_req_in = '{1'b1, wr, st, port, a, 16'($urandom)};
    fetch_pc_in = pc;
    tick;
    e = run && s < 3 && !(st && !port && sec_of(pc) != 2) &&
        (wr ? mlk[5-2*s -: 2] == 2'h3 : mlk[5-2*s]);
    chk({flash_grant_out, flash_denied_out, flash_sec_out},
        {e[0], !e[0], 2'(s)});
  endtask : flash
  task automatic lock(input logic [5:0] v);
    lock_wdata_in = v;
    lock_wr_in = 1'b1;
    lock_from_port_in = 1'($urandom);
    tick;
    lock_wr_in = 1'b0;
    if ((v & mlk) == v) mlk = v;
    tick;
    chk(locks_out, mlk);
    for (int i = 0; i < 6; i++)
      flash(17'h0e800 + 17'(i[2:1]) * 17'h1000, i[0], 0, 1, 0);
    flash_req_in.req = 1'b0;
  endtask : lock
  initial begin
    void'($urandom(48));
    repeat (6) @(posedge clk_in);
    chk({locks_out, fuse_out}, 14'h3fff);
    #1;
    nrst_in = 1'b1;
    flash(17'h0, 0, 0, 0, 17'h0);
    chk(init_done_out, 1'b0);
    flash_req_in.req = 1'b0;
    tick;
    chk(init_done_out, 1'b1);
    chk({cal_osc_out, cal_adc_out}, {8'(`NSPM_CAL0_VAL), 8'(`NSPM_CAL1_VAL)});
    run = 1;
    flash(17'h00010, 1, 1, 0, 17'h00100);
    flash(17'h00010, 1, 1, 0, 17'h0f000);
    flash(17'h10fff, 1, 1, 0, 17'h10000);
    flash(17'h0efff, 1, 1, 0, 17'h10fff);
    flash(17'h0ffff, 1, 0, 1, 17'h00000);
    flash(17'h11000, 0, 0, 0, 17'h00000);
    flash_req_in.req = 1'b0;
    lock(6'h2f);
    lock(6'h23);
    lock(6'h22);
    lock(6'h3f);
    u_nspm_prog_model.write_fuse(8'h5c, 1'b0);
    tick;
    chk(fuse_out, 8'hff);
    u_nspm_prog_model.write_fuse(8'h5c, 1'b1);
    tick;
    chk(fuse_out, 8'h5c);
    w = $urandom;
    user_wdata_in = w[15:0];
    user_wr_in = 1'b1;
    sig_rd_in = 1'b1;
    tick;
    user_wr_in = 1'b0;
    sig_rd_in = 1'b0;
    chip_erase_in = 1'b1;
    tick;
    chip_erase_in = 1'b0;
    run = 0;
    chk(erase_busy_out, 1'b1);
    for (int n = 0; n < 40 && erase_busy_out === 1'b1; n++) begin
      chk(locks_out, mlk);
      flash(17'h0, 0, 0, 1, 17'h0);
    end
    flash_req_in.req = 1'b0;
    run = 1;
    tick;
    chk(locks_out, 6'h3f);
    chk(user_rdata_out, w[15:0]);
    chk(sig_rdata_out, 16'h1234);
    user_erase_in = 1'b1;
    tick;
    user_erase_in = 1'b0;
    tick;
    chk(user_rdata_out, 16'hffff);
    for (int i = 0; i < 32; i++) begin
      w = $urandom;
      data_addr_in = i >= 16 ? w[15:0] :
        16'h0fff + 16'(i / 2) * 16'h0800 + 16'(i % 2);
      data_wr_in = w[16];
      tick;
      e = data_addr_in < 16'h1000 ? 0 : data_addr_in < 16'h1800 ? 1 :
          data_addr_in < 16'h2000 ? 2 : 3;
      chk({data_region_out, data_wr_en_out, data_rd_zero_out},
          {3'(e), w[16] && e != 2, e == 2});
    end
    end_sim;
  end
endmodule : nspm_top_bench
